// ===== include/pbov_consts.vh
// constants for the port register block and port b low-pin override logic
// Contract
// (R1) software sets b0 direction before route-u wave
// (R2) route-u steer bit gates chan a onto b0
// (R3) three-wire mode leaves b0 input for data
// (R4) b2 override: two-wire default pins or route v
// (R5) b2 override value zero in two-wire, else wave
// (R6) b1 value: shift bit under serial mode, else b
// (R7) b0 override: two-wire default pins or route u
// (R8) b0 override value zero in two-wire, else wave
// (R9) synced b0 feeds pin-change 8 and serial data
// (R10) synced b2 feeds pin-change 10 and serial clock
// (R11) output latch registers, read/write, reset zero
// (R12) direction registers reset zero, one means output
// (R13) pin level registers return sampled pin levels
// (R14) three-wire output drives b1 only when direction set
// (R15) override enables replace register output, direction, pull-up
`ifndef PBOV_CONSTS_VH
`define PBOV_CONSTS_VH
// register indexes; byte address is four times the index
`define PBOV_IDX_A_PIN 3'h0
`define PBOV_IDX_A_DIR 3'h1
`define PBOV_IDX_A_OUT 3'h2
`define PBOV_IDX_B_PIN 3'h3
`define PBOV_IDX_B_DIR 3'h4
`define PBOV_IDX_B_OUT 3'h5
`define PBOV_IDX_STEER 3'h6
`define PBOV_IDX_SERIAL 3'h7
`define PBOV_RST_BYTE 8'h00
// steering register fields
`define PBOV_STEER_AU 0
`define PBOV_STEER_AV 1
`define PBOV_STEER_BU 2
`define PBOV_STEER_AEN 3
`define PBOV_STEER_BEN 4
// serial control register fields
`define PBOV_SER_TWO 0
`define PBOV_SER_THREE 1
`define PBOV_SER_POS 2
`define PBOV_RESP_OKAY 2'h0
`define PBOV_RESP_SLVERR 2'h2
`endif

// ===== rtl/pbov_port.v
// port a/b registers with port b low-pin alternate function overrides
`timescale 1ns/10ps
`include "pbov_consts.vh"
module pbov_port #(
  parameter WIDTH = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [WIDTH-1:0] pa_in,
  output reg [WIDTH-1:0] pa_out,
  output reg [WIDTH-1:0] pa_oe,
  output reg [WIDTH-1:0] pa_pullup,
  input wire [WIDTH-1:0] pb_in,
  output reg [WIDTH-1:0] pb_out,
  output reg [WIDTH-1:0] pb_oe,
  output reg [WIDTH-1:0] pb_pullup,
  input wire timer1_chan_a_wave,
  input wire timer1_chan_b_wave,
  input wire serial_shift_msb_out,
  input wire serial_wire_mode_cond,
  output reg pin_change_source_8,
  output reg pin_change_source_10,
  output reg three_wire_serial_input,
  output reg two_wire_data_in,
  output reg serial_clock_input
);

  // ************************************************
  // register state
  // ************************************************
  reg [WIDTH-1:0] a_output_latch_q;
  reg [WIDTH-1:0] a_direction_q;
  reg [WIDTH-1:0] b_output_latch_q;
  reg [WIDTH-1:0] b_direction_q;
  reg [4:0] timer1_output_steer_reg_q;
  reg [2:0] serial_ctrl_q;
  reg [WIDTH-1:0] a_sync1_q;
  reg [WIDTH-1:0] a_pin_levels_q;
  reg [WIDTH-1:0] b_sync1_q;
  reg [WIDTH-1:0] b_pin_levels_q;
  reg aw_hold_q;
  reg [2:0] aw_idx_q;
  reg aw_ok_q;
  reg w_hold_q;
  reg [31:0] w_data_q;
  reg w_strb_q;

  // ************************************************
  // bus decode helpers
  // ************************************************
  function [2:0] idx_of;
    input [4:0] addr;
    begin
      idx_of = addr[4:2];
    end
  endfunction

  // all eight indexes are mapped; unaligned addresses are refused
  function mapped;
    input [4:0] addr;
    begin
      mapped = (addr[1:0] == 2'h0);
    end
  endfunction

  // pull-up only while the pin is an input
  function [WIDTH-1:0] pull_of;
    input [WIDTH-1:0] latch;
    input [WIDTH-1:0] dir;
    begin
      pull_of = latch & ~dir;
    end
  endfunction

  // two-wire mode on the default pins holds a pin whose direction bit is set
  function two_wire_hold;
    input two_wire;
    input default_pins;
    input dir_bit;
    begin
      two_wire_hold = two_wire & default_pins & dir_bit;
    end
  endfunction

  // ************************************************
  // override logic
  // ************************************************
  wire timer1_chan_a_route_u = timer1_output_steer_reg_q[`PBOV_STEER_AU];
  wire timer1_chan_a_route_v = timer1_output_steer_reg_q[`PBOV_STEER_AV];
  wire timer1_chan_b_route_u = timer1_output_steer_reg_q[`PBOV_STEER_BU];
  wire timer1_chan_a_out_en = timer1_output_steer_reg_q[`PBOV_STEER_AEN];
  wire timer1_chan_b_out_en = timer1_output_steer_reg_q[`PBOV_STEER_BEN];
  wire serial_two_wire_active = serial_ctrl_q[`PBOV_SER_TWO];
  wire serial_three_wire_active = serial_ctrl_q[`PBOV_SER_THREE];
  // default position is select low
  wire serial_default_pins = ~serial_ctrl_q[`PBOV_SER_POS];
  wire b0_direction_bit = b_direction_q[0];
  wire b2_direction_reg_bit = b_direction_q[2];
  wire b1_output_bit = b_output_latch_q[1];

  wire tw0 = two_wire_hold(serial_two_wire_active, serial_default_pins, b0_direction_bit);
  wire tw2 = two_wire_hold(serial_two_wire_active, serial_default_pins, b2_direction_reg_bit);
  wire b0_pin_value_override_en = tw0 | (timer1_chan_a_out_en & timer1_chan_a_route_u); // [R7] [R2]
  wire b0_pin_value_override_val = tw0 ? 1'b0 : timer1_chan_a_wave; // [R8]
  wire b2_pin_value_override_en = tw2 | (timer1_chan_a_out_en & timer1_chan_a_route_v); // [R4]
  wire b2_pin_value_override_val = tw2 ? 1'b0 : timer1_chan_a_wave; // [R5]
  // three-wire data out takes b1 value; direction stays with software
  wire b1_serial = serial_three_wire_active & serial_wire_mode_cond & serial_default_pins;
  wire b1_pin_value_override_en = b1_serial | (timer1_chan_b_out_en & timer1_chan_b_route_u); // [R14]
  wire b1_pin_value_override_val = b1_serial ? serial_shift_msb_out : timer1_chan_b_wave; // [R6]
  // two-wire pins drive low only, open-drain style
  wire direction_override_en = serial_two_wire_active & serial_default_pins;
  wire b0_direction_override_val = (serial_shift_msb_out | b_output_latch_q[0]) & b0_direction_bit;
  wire b2_direction_override_val = b_output_latch_q[2] & b2_direction_reg_bit;

  reg [WIDTH-1:0] pb_out_d;
  reg [WIDTH-1:0] pb_oe_d;
  reg [WIDTH-1:0] pb_pu_d;
  always @* begin
    pb_out_d = b_output_latch_q;
    pb_oe_d = b_direction_q;
    pb_pu_d = pull_of(b_output_latch_q, b_direction_q); // [R11]
    if (b0_pin_value_override_en) begin
      pb_out_d[0] = b0_pin_value_override_val; // [R15]
    end
    if (b1_pin_value_override_en) begin
      pb_out_d[1] = b1_pin_value_override_val; // [R15]
    end
    if (b2_pin_value_override_en) begin
      pb_out_d[2] = b2_pin_value_override_val; // [R15]
    end
    if (direction_override_en) begin
      pb_oe_d[0] = b0_direction_override_val; // [R15]
      pb_oe_d[2] = b2_direction_override_val;
      pb_pu_d[0] = 1'b0;
      pb_pu_d[2] = 1'b0;
    end
    pb_pu_d[1] = b1_output_bit & ~b_direction_q[1]; // [R14]
  end

  // ************************************************
  // bus slave and registers
  // ************************************************
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_hold_q | aw_take;
  wire w_have = w_hold_q | w_take;
  wire [2:0] aw_idx_d = aw_take ? idx_of(s_axi_awaddr) : aw_idx_q;
  wire aw_ok_d = aw_take ? mapped(s_axi_awaddr) : aw_ok_q;
  wire [31:0] wd = w_take ? s_axi_wdata : w_data_q;
  wire ws = w_take ? s_axi_wstrb[0] : w_strb_q;
  wire do_write = aw_have & w_have & ~s_axi_bvalid;
  wire wr_en = do_write & aw_ok_d & ws;

  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0;
    case (idx_of(s_axi_araddr))
      `PBOV_IDX_A_PIN: rd_d[WIDTH-1:0] = a_pin_levels_q; // [R13]
      `PBOV_IDX_A_DIR: rd_d[WIDTH-1:0] = a_direction_q;
      `PBOV_IDX_A_OUT: rd_d[WIDTH-1:0] = a_output_latch_q;
      `PBOV_IDX_B_PIN: rd_d[WIDTH-1:0] = b_pin_levels_q; // [R13]
      `PBOV_IDX_B_DIR: rd_d[WIDTH-1:0] = b_direction_q;
      `PBOV_IDX_B_OUT: rd_d[WIDTH-1:0] = b_output_latch_q;
      `PBOV_IDX_STEER: rd_d[4:0] = timer1_output_steer_reg_q;
      `PBOV_IDX_SERIAL: rd_d[2:0] = serial_ctrl_q;
      default: rd_d = 32'h0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      a_output_latch_q <= {WIDTH{1'b0}};
      a_direction_q <= {WIDTH{1'b0}};
      b_output_latch_q <= {WIDTH{1'b0}};
      b_direction_q <= {WIDTH{1'b0}};
      timer1_output_steer_reg_q <= 5'h00;
      serial_ctrl_q <= 3'h0;
      aw_hold_q <= 1'b0;
      aw_idx_q <= 3'h0;
      aw_ok_q <= 1'b0;
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PBOV_RESP_OKAY;
    end else begin
      aw_idx_q <= aw_idx_d;
      aw_ok_q <= aw_ok_d;
      w_data_q <= wd;
      w_strb_q <= ws;
      aw_hold_q <= aw_have & ~do_write;
      w_hold_q <= w_have & ~do_write;
      // accept one of each, then wait for the response to drain
      s_axi_awready <= ~aw_have & ~s_axi_bvalid & ~s_axi_awready;
      s_axi_wready <= ~w_have & ~s_axi_bvalid & ~s_axi_wready;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_ok_d ? `PBOV_RESP_OKAY : `PBOV_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_en) begin
        case (aw_idx_d)
          `PBOV_IDX_A_DIR: a_direction_q <= wd[WIDTH-1:0]; // [R12]
          `PBOV_IDX_A_OUT: a_output_latch_q <= wd[WIDTH-1:0]; // [R11]
          `PBOV_IDX_B_DIR: b_direction_q <= wd[WIDTH-1:0]; // [R12]
          `PBOV_IDX_B_OUT: b_output_latch_q <= wd[WIDTH-1:0]; // [R11]
          `PBOV_IDX_STEER: timer1_output_steer_reg_q <= wd[4:0]; // [R2]
          `PBOV_IDX_SERIAL: serial_ctrl_q <= wd[2:0];
          default: ;
        endcase
      end
    end
  end

  // ************************************************
  // read channel
  // ************************************************
  // reads run apart from writes, so a read may overlap a pending write
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `PBOV_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= mapped(s_axi_araddr) ? rd_d : 32'h0;
        s_axi_rresp <= mapped(s_axi_araddr) ? `PBOV_RESP_OKAY : `PBOV_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************
  // pin sampling and pin drive
  // ************************************************
  // sampled levels have no reset: value before two edges is undefined
  always @(posedge aclk) begin
    a_sync1_q <= pa_in;
    a_pin_levels_q <= a_sync1_q; // [R13]
    b_sync1_q <= pb_in;
    b_pin_levels_q <= b_sync1_q; // [R13]
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      pa_out <= {WIDTH{1'b0}};
      pa_oe <= {WIDTH{1'b0}};
      pa_pullup <= {WIDTH{1'b0}};
      pb_out <= {WIDTH{1'b0}};
      pb_oe <= {WIDTH{1'b0}};
      pb_pullup <= {WIDTH{1'b0}};
    end else begin
      pa_out <= a_output_latch_q;
      pa_oe <= a_direction_q; // [R12]
      pa_pullup <= pull_of(a_output_latch_q, a_direction_q); // [R11]
      pb_out <= pb_out_d;
      pb_oe <= pb_oe_d;
      pb_pullup <= pb_pu_d;
    end
  end

  // ************************************************
  // alternate input feeds
  // ************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_change_source_8 <= 1'b0;
      pin_change_source_10 <= 1'b0;
      three_wire_serial_input <= 1'b0;
      two_wire_data_in <= 1'b0;
      serial_clock_input <= 1'b0;
    end else begin
      pin_change_source_8 <= b_pin_levels_q[0]; // [R9]
      three_wire_serial_input <= b_pin_levels_q[0]; // [R9]
      two_wire_data_in <= b_pin_levels_q[0]; // [R9]
      pin_change_source_10 <= b_pin_levels_q[2]; // [R10]
      serial_clock_input <= b_pin_levels_q[2]; // [R10]
    end
  end

endmodule // pbov_port

// ===== tb/pbov_board.sv
// board model: level seen on each pin of one port
`timescale 1ns/10ps
module pbov_board (
  input wire [7:0] out,
  input wire [7:0] oe,
  input wire [7:0] pu,
  input wire [7:0] ext_en,
  input wire [7:0] ext_val,
  output wire [7:0] lvl
);
  // ****************
  // pin resolution
  // ****************
  // a floating pin without pull-up shows the inverse of its current out value
  assign lvl = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pu | ~out));
endmodule // pbov_board

// ===== tb/pbov_chk.sv
// checker for the port block bus handshake and pin feed relations
`timescale 1ns/10ps
module pbov_chk #(
  parameter WIDTH = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_arready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [WIDTH-1:0] pb_in,
  input wire [WIDTH-1:0] pa_oe,
  input wire [WIDTH-1:0] pa_pullup,
  input wire pin_change_source_8,
  input wire pin_change_source_10,
  input wire three_wire_serial_input,
  input wire two_wire_data_in,
  input wire serial_clock_input
);
  // ****************
  // properties
  // ****************
  reg [2:0] up_q;
  // pin feeds are ignored until the synchronizer has refilled after reset
  always @(posedge aclk) begin
    if (!aresetn) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_one: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response stood too long");
  a_r_one: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response stood too long");
  a_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
  a_b_cause: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready || s_axi_wready))
    else $error("write response without request");
  a_r_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arready))
    else $error("read response without request");
  a_b0_feed: assert property ((up_q == 3'h7 && $stable(pb_in[0])) [*4]
    |-> pin_change_source_8 == pb_in[0]) else $error("bit0 feed wrong");
  a_b2_feed: assert property ((up_q == 3'h7 && $stable(pb_in[2])) [*4]
    |-> serial_clock_input == pb_in[2]) else $error("bit2 feed wrong");
  a_feed_twins: assert property (pin_change_source_10 == serial_clock_input
    && three_wire_serial_input == pin_change_source_8 && two_wire_data_in == pin_change_source_8)
    else $error("feeds disagree");
  a_pull_in: assert property ((pa_pullup & pa_oe) == 8'h00)
    else $error("pull-up on driven pin");
  c_wr: cover property ($rose(s_axi_bvalid));
  c_rd: cover property ($rose(s_axi_rvalid));
  c_pc8: cover property ($rose(pin_change_source_8));
endmodule // pbov_chk
bind pbov_port pbov_chk #(.WIDTH(WIDTH)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_arready(s_axi_arready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .pb_in(pb_in), .pa_oe(pa_oe),
  .pa_pullup(pa_pullup), .pin_change_source_8(pin_change_source_8),
  .pin_change_source_10(pin_change_source_10), .serial_clock_input(serial_clock_input),
  .three_wire_serial_input(three_wire_serial_input), .two_wire_data_in(two_wire_data_in));

// ===== tb/testbench.sv
// self-checking bench for the port register and override block
`timescale 1ns/10ps
module testbench;
  reg aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  reg wa = 1'b0, wb = 1'b0, sh = 1'b0, wm = 1'b0;
  reg [4:0] awa = 5'h00, ara = 5'h00;
  reg [31:0] wd = 32'h0;
  reg [7:0] ae = 8'h00, av = 8'h00, be = 8'h00, bv = 8'h00;
  wire awr, wr_, bvl, arr, rvl, pc8, pc10, di3, di2, sck;
  wire [1:0] brs, rrs;
  wire [31:0] rd;
  wire [7:0] pai, pao, paoe, papu, pbi, pbo, pboe, pbpu;
  integer fail_count = 0, tests_run = 0, cyc = 0;
`define CHK(n, e, s) begin tests_run = tests_run + 1; if ((s) !== (e)) begin \
  fail_count = fail_count + 1; $display("[FAIL] %s exp %h got %h", n, e, s); end end
  pbov_port dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr_), .s_axi_bresp(brs), .s_axi_bvalid(bvl), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rrs), .s_axi_rvalid(rvl), .s_axi_rready(rry), .pa_in(pai), .pa_out(pao),
    .pa_oe(paoe), .pa_pullup(papu), .pb_in(pbi), .pb_out(pbo), .pb_oe(pboe),
    .pb_pullup(pbpu), .timer1_chan_a_wave(wa), .timer1_chan_b_wave(wb),
    .serial_shift_msb_out(sh), .serial_wire_mode_cond(wm), .pin_change_source_8(pc8),
    .pin_change_source_10(pc10), .three_wire_serial_input(di3), .two_wire_data_in(di2),
    .serial_clock_input(sck));
  pbov_board bda (.out(pao), .oe(paoe), .pu(papu), .ext_en(ae), .ext_val(av), .lvl(pai));
  pbov_board bdb (.out(pbo), .oe(pboe), .pu(pbpu), .ext_en(be), .ext_val(bv), .lvl(pbi));
  // ****************
  // bus tasks
  // ****************
  initial begin
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fail_count = fail_count + 1;
      final_report;
    end
  end
  task wr(input [4:0] a, input [7:0] d, input [1:0] er);
    reg ta, tw;
    begin
      ta = 1'b0;
      tw = 1'b0;
      @(posedge aclk);
      awa <= a;
      wd <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      while (!(ta && tw)) begin
        @(posedge aclk);
        if (!ta && awr) begin
          ta = 1'b1;
          awv <= 1'b0;
        end
        if (!tw && wr_) begin
          tw = 1'b1;
          wv <= 1'b0;
        end
      end
      while (!bvl) @(posedge aclk);
      bry <= 1'b0;
      `CHK("bresp", er, brs)
    end
  endtask
  task rd_(input [4:0] a, input [7:0] e, input [1:0] er);
    begin
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      @(posedge aclk);
      while (!arr) @(posedge aclk);
      arv <= 1'b0;
      while (!rvl) @(posedge aclk);
      rry <= 1'b0;
      `CHK("rdata", {24'h0, e}, rd)
      `CHK("rresp", er, rrs)
    end
  endtask
  task t_regs;
    begin
      rd_(5'h04, 8'h00, 2'h0);
      rd_(5'h14, 8'h00, 2'h0);
      wr(5'h08, 8'hA5, 2'h0);
      wr(5'h04, 8'h3C, 2'h0);
      wr(5'h09, 8'hFF, 2'h2);
      rd_(5'h08, 8'hA5, 2'h0);
      rd_(5'h0A, 8'h00, 2'h2);
      wr(5'h14, 8'h5A, 2'h0);
      wr(5'h10, 8'hC3, 2'h0);
      ae <= 8'hC3;
      av <= 8'h41;
      be <= 8'h3C;
      bv <= 8'h24;
      repeat (4) @(posedge aclk);
      `CHK("pa_pullup", 8'h81, papu)
      `CHK("pa_drive", 16'hA53C, {pao, paoe})
      `CHK("pb_out", 8'h5A, pbo)
      `CHK("pb_pullup", 8'h18, pbpu)
      `CHK("pb_oe", 8'hC3, pboe)
      rd_(5'h00, 8'h65, 2'h0);
      rd_(5'h0C, 8'h66, 2'h0);
      `CHK("pc10", 1'b1, pc10)
      `CHK("pc8", 1'b0, pc8)
      $display("register test done");
    end
  endtask
  task t_ovr;
    begin
      wr(5'h14, 8'h00, 2'h0);
      wr(5'h10, 8'h07, 2'h0);
      wr(5'h18, 8'h09, 2'h0);
      wa <= 1'b1;
      repeat (2) @(posedge aclk);
      `CHK("b0 wave", 1'b1, pbo[0])
      wr(5'h18, 8'h0A, 2'h0);
      repeat (2) @(posedge aclk);
      `CHK("b2 wave", 1'b1, pbo[2])
      `CHK("b0 latch", 1'b0, pbo[0])
      wr(5'h18, 8'h0B, 2'h0);
      wr(5'h1C, 8'h01, 2'h0);
      repeat (2) @(posedge aclk);
      `CHK("b0 two", 1'b0, pbo[0])
      `CHK("b2 two", 1'b0, pbo[2])
      `CHK("b0 oe two", 1'b0, pboe[0])
      wr(5'h1C, 8'h05, 2'h0);
      repeat (2) @(posedge aclk);
      `CHK("b0 moved", 1'b1, pbo[0])
      wr(5'h1C, 8'h02, 2'h0);
      wr(5'h18, 8'h14, 2'h0);
      wr(5'h10, 8'h02, 2'h0);
      sh <= 1'b1;
      wm <= 1'b1;
      bv <= 8'h01;
      be <= 8'h01;
      repeat (5) @(posedge aclk);
      `CHK("b1 shift", 2'h3, {pbo[1], pboe[1]})
      `CHK("serial in", 3'h7, {di2, di3, pc8})
      `CHK("serial clk", 2'h3, {sck, pc10})
      wm <= 1'b0;
      sh <= 1'b0;
      wb <= 1'b1;
      repeat (2) @(posedge aclk);
      `CHK("b1 wave", 1'b1, pbo[1])
      wr(5'h10, 8'h00, 2'h0);
      wr(5'h14, 8'h02, 2'h0);
      wm <= 1'b1;
      repeat (2) @(posedge aclk);
      `CHK("b1 input", 2'h1, {pboe[1], pbpu[1]})
      $display("override test done");
    end
  endtask
  task t_rst;
    begin
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      `CHK("reset pins", 48'h0, {pao, paoe, papu, pbo, pboe, pbpu})
      aresetn <= 1'b1;
      rd_(5'h14, 8'h00, 2'h0);
      rd_(5'h10, 8'h00, 2'h0);
      $display("reset test done");
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_ovr;
    t_rst;
    final_report;
  end
endmodule // testbench
